/* hw/gpe_top.sv */
`timescale 1ns/1ps
`default_nettype none

// Function
// - Polarity bit selects low or high active
// - Port 2 redirect suppresses notifications, drives event
// - Port 3 redirect suppresses notifications, drives event
// - Event appears on pin 7 alternate only
// - Status bit 1 shows port 2 event
// - Status bit 2 shows port 3 event
// - No status without redirect enable
module gpe_top
    import gpe_pkg::*;
(
    // APB clock and fundamental reset
    input wire logic pclk,
    input wire logic presetn,
    // Non-fundamental reset, spares the sticky bits
    input wire logic hot_reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Hot-plug events from ports 2 and 3, asynchronous levels
    input wire logic [GPE_NUM_PORTS-1:0] hp_event,
    // Regular notification requests per port
    input wire gpe_notify_t p2_notify_req,
    input wire gpe_notify_t p3_notify_req,
    // Notifications passed on
    output gpe_notify_t p2_notify,
    output gpe_notify_t p3_notify,
    // Pin 7 alternate function
    output logic general_event_output,
    output logic gpio7_alt_active
);

    // ********************************************************
    // Register state
    // ********************************************************
    gpe_ctl_t ctl_q;
    gpe_ctl_t ctl_d;
    logic alt_q;
    logic alt_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic err_q;
    logic err_d;
    logic hot_q1;
    logic hot_q2;
    logic [GPE_NUM_PORTS-1:0] ev_sync;
    logic [GPE_NUM_PORTS-1:0] ev_status;
    logic [GPE_NUM_PORTS-1:0] redir;
    logic access;
    logic wr;
    logic hit_ctl;
    logic hit_sts;
    logic hit_pin;
    logic any_event;
    logic [31:0] ctl_word;
    logic [31:0] sts_word;
    logic [31:0] pin_word;

    // ********************************************************
    // Input synchronisers
    // ********************************************************
    for (genvar i = 0; i < GPE_NUM_PORTS; i++) begin : g_sync
        gpe_sync u_sync (
            .pclk(pclk),
            .presetn(presetn),
            .d(hp_event[i]),
            .q(ev_sync[i])
        );
    end

    // Hot reset is asynchronous to pclk, used synchronously
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hot_q1 <= 1'b1;
            hot_q2 <= 1'b1;
        end else begin
            hot_q1 <= hot_reset_n;
            hot_q2 <= hot_q1;
        end
    end

    // ********************************************************
    // Per-port redirect
    // ********************************************************
    assign redir = {ctl_q.port3_event_redirect_enable,
                    ctl_q.port2_event_redirect_enable};

    gpe_port u_port2 (
        .pclk(pclk),
        .presetn(presetn),
        .redirect_en(redir[0]),
        .hp_event(ev_sync[0]),
        .notify_req(p2_notify_req),
        .notify_out(p2_notify),
        .event_status(ev_status[0])
    );

    gpe_port u_port3 (
        .pclk(pclk),
        .presetn(presetn),
        .redirect_en(redir[1]),
        .hp_event(ev_sync[1]),
        .notify_req(p3_notify_req),
        .notify_out(p3_notify),
        .event_status(ev_status[1])
    );

    // ********************************************************
    // APB decode
    // ********************************************************
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign hit_ctl = (paddr == GPE_CTL_OFFSET);
    assign hit_sts = (paddr == GPE_STS_OFFSET);
    assign hit_pin = (paddr == GPE_PIN_OFFSET);

    always_comb begin
        ctl_word = GPE_CTL_RESET;
        ctl_word[GPE_POL_BIT] = ctl_q.event_polarity_invert;
        ctl_word[GPE_P2_EN_BIT] = ctl_q.port2_event_redirect_enable;
        ctl_word[GPE_P3_EN_BIT] = ctl_q.port3_event_redirect_enable;
        sts_word = GPE_STS_RESET;
        // Status follows redirect, never without it
        sts_word[GPE_P2_STS_BIT] = ev_status[0] & redir[0];
        sts_word[GPE_P3_STS_BIT] = ev_status[1] & redir[1];
        pin_word = 32'h0000_0000;
        pin_word[GPE_ALT_BIT] = alt_q;
    end

    // ********************************************************
    // Register writes and read data
    // ********************************************************
    always_comb begin
        ctl_d = ctl_q;
        alt_d = alt_q;
        rdata_d = rdata_q;
        err_d = 1'b0;
        if (wr && hit_ctl && pstrb[0]) begin
            ctl_d.event_polarity_invert = pwdata[GPE_POL_BIT];
            ctl_d.port2_event_redirect_enable = pwdata[GPE_P2_EN_BIT];
            ctl_d.port3_event_redirect_enable = pwdata[GPE_P3_EN_BIT];
        end
        if (wr && hit_pin && pstrb[0]) begin
            alt_d = pwdata[GPE_ALT_BIT];
        end
        if (access && !pwrite) begin
            rdata_d = 32'h0000_0000;
            if (hit_ctl) begin
                rdata_d = ctl_word;
            end else if (hit_sts) begin
                rdata_d = sts_word;
            end else if (hit_pin) begin
                rdata_d = pin_word;
            end
        end
        // Unmapped or status write answers with an error
        if (access && !(hit_ctl || hit_pin || (hit_sts && !pwrite))) begin
            err_d = 1'b1;
        end
    end

    // Sticky control: only the fundamental reset clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= '0;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    // Pin mux select is not sticky, hot reset clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_q <= GPE_ALT_RESET;
        end else if (!hot_q2) begin
            alt_q <= GPE_ALT_RESET;
        end else begin
            alt_q <= alt_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // Read data comes straight from the word; held copy only
    // keeps the port stable between transfers
    assign prdata = (access && !pwrite) ? rdata_d : rdata_q;
    assign pready = 1'b1;
    assign pslverr = access & err_d;

    // ********************************************************
    // Event pin
    // ********************************************************
    logic pin_q;
    logic pin_d;

    always_comb begin
        any_event = |(ev_status & redir);
        // Deasserted level when pin is not in alternate function
        pin_d = ctl_q.event_polarity_invert
              ? (alt_q & any_event)
              : ~(alt_q & any_event);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b1;
        end else begin
            pin_q <= pin_d;
        end
    end

    assign general_event_output = pin_q;
    assign gpio7_alt_active = alt_q;

endmodule

`default_nettype wire

/* hw/gpe_pkg.sv */
package gpe_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [11:0] GPE_CTL_OFFSET = 12'h35C;
    localparam logic [11:0] GPE_STS_OFFSET = 12'h360;
    localparam logic [11:0] GPE_PIN_OFFSET = 12'h364;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int GPE_POL_BIT = 0;
    localparam int GPE_P2_EN_BIT = 2;
    localparam int GPE_P3_EN_BIT = 3;
    localparam int GPE_P2_STS_BIT = 1;
    localparam int GPE_P3_STS_BIT = 2;
    localparam int GPE_ALT_BIT = 0;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [31:0] GPE_CTL_RESET = 32'h0000_0000;
    localparam logic [31:0] GPE_STS_RESET = 32'h0000_0000;
    localparam logic GPE_ALT_RESET = 1'b0;
    localparam int GPE_NUM_PORTS = 2;

    // ********************************************************
    // Sticky control fields
    // ********************************************************
    typedef struct packed {
        logic port3_event_redirect_enable;
        logic port2_event_redirect_enable;
        logic event_polarity_invert;
    } gpe_ctl_t;

    // Regular notification requests and the notifications passed on
    typedef struct packed {
        logic intx;
        logic msi;
        logic pme;
    } gpe_notify_t;

endpackage

/* hw/gpe_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module gpe_sync
    import gpe_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic d,
    output logic q
);

    logic meta_q;
    logic meta_d;
    logic q_d;
    logic out_q;

    always_comb begin
        meta_d = d;
        q_d = meta_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            out_q <= q_d;
        end
    end

    assign q = out_q;

endmodule

`default_nettype wire

/* hw/gpe_port.sv */
`timescale 1ns/1ps
`default_nettype none

module gpe_port
    import gpe_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic redirect_en,
    input wire logic hp_event,
    input wire gpe_notify_t notify_req,
    // Results
    output gpe_notify_t notify_out,
    output logic event_status
);

    logic status_q;
    logic status_d;
    gpe_notify_t notify_q;
    gpe_notify_t notify_d;

    always_comb begin
        // Redirected port loses its message notifications
        notify_d = redirect_en ? '0 : notify_req;
        // Status only while redirected and event pending
        status_d = redirect_en & hp_event;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 1'b0;
            notify_q <= '0;
        end else begin
            status_q <= status_d;
            notify_q <= notify_d;
        end
    end

    assign notify_out = notify_q;
    assign event_status = status_q;

endmodule

`default_nettype wire

/* verif/gpe_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks
// ****
module gpe_assertions
    import gpe_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB writes
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    // Events and outputs
    input wire logic [GPE_NUM_PORTS-1:0] hp_event,
    input wire gpe_notify_t p2_notify_req,
    input wire gpe_notify_t p3_notify_req,
    input wire gpe_notify_t p2_notify,
    input wire gpe_notify_t p3_notify,
    input wire logic general_event_output,
    input wire logic gpio7_alt_active
);
    gpe_ctl_t ctl_q;
    wire logic pol = ctl_q.event_polarity_invert;
    wire logic en2 = ctl_q.port2_event_redirect_enable;
    wire logic en3 = ctl_q.port3_event_redirect_enable;

    // Shadow of control, untouched by hot reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= '0;
        end else if (psel && penable && pwrite && pstrb[0]
                     && paddr == GPE_CTL_OFFSET) begin
            ctl_q <= {pwdata[3:2], pwdata[0]};
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_p2_sup; en2 |=> p2_notify == 3'h0; endproperty
    property p_p3_sup; en3 |=> p3_notify == 3'h0; endproperty
    property p_p2_pass; !en2 |=> p2_notify == $past(p2_notify_req);
    endproperty
    property p_p3_pass; !en3 |=> p3_notify == $past(p3_notify_req);
    endproperty
    property p_alt_off;
        !gpio7_alt_active |=> general_event_output == !$past(pol);
    endproperty
    property p_no_en;
        !en2 && !en3 |=> general_event_output == !$past(pol);
    endproperty
    property p_p2_pin; (hp_event[0] && en2 && gpio7_alt_active) [*5]
        |=> general_event_output == $past(pol); endproperty
    property p_p3_pin; (hp_event[1] && en3 && gpio7_alt_active) [*5]
        |=> general_event_output == $past(pol); endproperty

    a_p2_sup: assert property (p_p2_sup) else $error("p2 not muted");
    a_p3_sup: assert property (p_p3_sup) else $error("p3 not muted");
    a_p2_pass: assert property (p_p2_pass) else $error("p2 lost");
    a_p3_pass: assert property (p_p3_pass) else $error("p3 lost");
    a_alt_off: assert property (p_alt_off) else $error("pin no alt");
    a_no_en: assert property (p_no_en) else $error("pin no enable");
    a_p2_pin: assert property (p_p2_pin) else $error("p2 pin");
    a_p3_pin: assert property (p_p3_pin) else $error("p3 pin");

    c_pin: cover property (general_event_output == pol && gpio7_alt_active);
    c_both: cover property (en2 && en3 && hp_event == 2'h3);
    c_mute: cover property (en2 && p2_notify_req != 3'h0);
endmodule

bind gpe_top gpe_assertions u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .hp_event, .p2_notify_req,
    .p3_notify_req, .p2_notify, .p3_notify, .general_event_output,
    .gpio7_alt_active);
`default_nettype wire

/* verif/gpe_event_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// System side watching the event pin
// ****
module gpe_event_monitor (
    // Pin and programmed polarity
    input wire logic pin,
    input wire logic pol,
    // Event seen
    output logic active
);
    assign active = (pin === pol);
endmodule
`default_nettype wire

/* verif/gpe_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module gpe_top_tb_top
    import gpe_pkg::*;
    ;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic hot_reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] hp_event = 2'h0;
    gpe_notify_t p2_req = 3'h0;
    gpe_notify_t p3_req = 3'h0;
    gpe_notify_t p2_n, p3_n;
    logic [31:0] prdata, rd, ctl;
    logic pready, pslverr, err, gev, alt, active;
    int n_fail = 0;
    int cmp_count = 0;

    always #5 pclk = ~pclk;

    gpe_top uut (.pclk(pclk), .presetn(presetn), .hot_reset_n(hot_reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hp_event(hp_event), .p2_notify_req(p2_req),
        .p3_notify_req(p3_req), .p2_notify(p2_n), .p3_notify(p3_n),
        .general_event_output(gev), .gpio7_alt_active(alt));
    gpe_event_monitor u_mon (.pin(gev), .pol(ctl[0]), .active(active));

    // ****
    // Bus, compare and expectations
    // ****
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] sts_exp(input logic [31:0] c,
                                            input logic [1:0] e);
        return {29'h0, e[1] & c[3], e[0] & c[2], 1'b0};
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        results();
    end

    initial begin
        int r;
        logic [1:0] ev;
        void'($urandom(2494));
        ctl = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        hot_reset_n <= 1'b1;
        @(posedge pclk);
        chk(gev, 32'h1);
        apb(1'b0, GPE_STS_OFFSET, 32'h0);
        chk(rd, GPE_STS_RESET);
        apb(1'b1, GPE_STS_OFFSET, 32'hFFFF_FFFF);
        chk(err, 32'h1);
        apb(1'b0, 12'h100, 32'h0);
        chk(err, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, GPE_CTL_OFFSET, 32'hFFFF_FFFF);
        apb(1'b0, GPE_CTL_OFFSET, 32'h0);
        chk(rd, 32'hD);
        $display("test registers done");
        // First 16 walk every mode with both events, rest random
        for (int i = 0; i < 24; i++) begin
            r = (i < 16) ? i : $urandom;
            ctl = {28'h0, r[2:1], 1'b0, r[0]};
            ev = (i < 16) ? 2'h3 : r[5:4];
            apb(1'b1, GPE_CTL_OFFSET, ctl);
            apb(1'b1, GPE_PIN_OFFSET, {31'h0, r[3]});
            p2_req <= gpe_notify_t'(3'($urandom));
            p3_req <= gpe_notify_t'(3'($urandom));
            hp_event <= ev;
            repeat (6) @(posedge pclk);
            chk(p2_n, ctl[2] ? 3'h0 : p2_req);
            chk(p3_n, ctl[3] ? 3'h0 : p3_req);
            chk(active, r[3] && sts_exp(ctl, ev) != 32'h0);
            apb(1'b0, GPE_STS_OFFSET, 32'h0);
            chk(rd, sts_exp(ctl, ev));
            hp_event <= 2'h0;
            repeat (6) @(posedge pclk);
            chk(active, 32'h0);
        end
        $display("test events done");
        apb(1'b1, GPE_CTL_OFFSET, 32'hD);
        apb(1'b1, GPE_PIN_OFFSET, 32'h1);
        hot_reset_n <= 1'b0;
        repeat (5) @(posedge pclk);
        hot_reset_n <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, GPE_CTL_OFFSET, 32'h0);
        chk(rd, 32'hD);
        apb(1'b0, GPE_PIN_OFFSET, 32'h0);
        chk(rd, 32'h0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, GPE_CTL_OFFSET, 32'h0);
        chk(rd, 32'h0);
        $display("test sticky done");
        results();
    end
endmodule
`default_nettype wire
